/* File: design/fscs_cfg.svh */
// Constants of the fuse and identification store: bit positions, reset values, selectors.
// Assumes inclusion by bare name from the package and design modules.
// Summary of operation
// - Three fuse bytes; programmed reads 0, unprogrammed reads 1.
// - Extended bits 3..1 select brown-out level, default 7 (all bits 1).
// - Extended bit 0 factory test default 1; bits 7..4 read 1.
// - High bit 7 debug enable default 1; bit 6 scan port default 0.
// - High bit 5 serial programming enable, default programmed.
// - Serial programming mode cannot change the serial-enable fuse.
// - High bit 4 programmed forces watchdog on; default unprogrammed.
// - High bit 3 programmed keeps EEPROM on chip erase.
// - High bits 2..1 boot size default 0; bit 0 reset vector default 1.
// - Low bits 3..0 clock source default internal RC; bit 7 divides by 8.
// - Low bits 5,4 start-up time default 1 and 0.
// - Low bit 6 programmed outputs system clock on a pin.
// - Chip erase leaves every fuse bit unchanged.
// - Fuse writes blocked while memory lock bit 1 is programmed.
// - Fuses latched on programming entry; new values wait for the next entry or a power-up outside programming mode.
// - EEPROM-keep fuse takes effect immediately once programmed.
// - Normal mode latches fuses at power-up.
// - Three identification bytes at addresses 0..2, separate space.
// - Identification reads ignore lock bits.
// - Byte 0 maker, byte 1 memory size, byte 2 exact part.
// - Trim byte at high byte of address 0, copied to trim register at power-up.
// - Chip erase clears lock bits only after program memory erase completes.
`ifndef FSCS_CFG_SVH
`define FSCS_CFG_SVH

`define FSCS_EXT_RESET     8'hFF
`define FSCS_HIGH_RESET    8'h99
`define FSCS_LOW_RESET     8'h62
`define FSCS_EXT_UNUSED    8'hF0
`define FSCS_LOCK_RESET    8'hFF
`define FSCS_ERASED_BYTE   8'hFF

`define FSCS_SEL_LOW       2'h0
`define FSCS_SEL_HIGH      2'h1
`define FSCS_SEL_EXT       2'h2
`define FSCS_SEL_LOCK      2'h3

`define FSCS_ID_ADDR_MAKER 2'h0
`define FSCS_ID_ADDR_SIZE  2'h1
`define FSCS_ID_ADDR_PART  2'h2

`define FSCS_BIT_DEBUG     7
`define FSCS_BIT_SCAN      6
`define FSCS_BIT_SERIAL    5
`define FSCS_BIT_WDOG      4
`define FSCS_BIT_EEKEEP    3
`define FSCS_BIT_RSTVEC    0
`define FSCS_BIT_DIV8      7
`define FSCS_BIT_CLKOUT    6
`define FSCS_BIT_LOCK1     0

`endif

/* File: design/fscs_fuse_decode.sv */
// Maps latched fuse bytes, and the live keep-EEPROM bit, to active-high configuration fields.
// Assumes fuse bytes read 0 when programmed.
`timescale 1ns/1ps
`include "fscs_cfg.svh"
`default_nettype none

module fscs_fuse_decode (
   // Latched fuses and live keep-EEPROM bit
   input  wire fscs_pkg::fscs_fuses_t  fuses,
   input  wire logic                   eeKeepLive,
   // Decoded fields
   output fscs_pkg::fscs_config_t      cfg
);
   always_comb begin
      cfg.brownoutLevel      = fuses.ext[3:1];
      cfg.factoryTest        = ~fuses.ext[0];
      cfg.debugEn            = ~fuses.high[`FSCS_BIT_DEBUG];
      cfg.scanPortEn         = ~fuses.high[`FSCS_BIT_SCAN];
      cfg.serialProgEn       = ~fuses.high[`FSCS_BIT_SERIAL];
      cfg.watchdogForcedOn   = ~fuses.high[`FSCS_BIT_WDOG];
      cfg.eepromKeepOnErase  = ~eeKeepLive;
      cfg.bootSize           = fuses.high[2:1];
      cfg.resetVectorBoot    = ~fuses.high[`FSCS_BIT_RSTVEC];
      cfg.clockDivideByEight = ~fuses.low[`FSCS_BIT_DIV8];
      cfg.clockPinOutput     = ~fuses.low[`FSCS_BIT_CLKOUT];
      cfg.startupTime        = fuses.low[5:4];
      cfg.clockSource        = fuses.low[3:0];
   end
endmodule : fscs_fuse_decode

`default_nettype wire

/* File: design/fscs_ident_rom.sv */
// Read-only identification space: three ident bytes and the oscillator trim byte.
// Assumes a registered read is acceptable to the caller.
`timescale 1ns/1ps
`include "fscs_cfg.svh"
`default_nettype none

module fscs_ident_rom #(
   parameter logic [7:0] MAKER_CODE = 8'hA5,  // Arbitrary value
   parameter logic [7:0] SIZE_CODE  = 8'h5A,  // Arbitrary value
   parameter logic [7:0] PART_CODE  = 8'h3C,  // Arbitrary value
   parameter logic [7:0] TRIM_CODE  = 8'h80   // Arbitrary value
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Lookup
   input  wire logic [1:0] addr,
   input  wire logic       highByte,
   output logic      [7:0] dataOut
);
   logic [7:0] state_reg;
   logic [7:0] state_next;

   always_comb begin
      state_next = 8'hFF;
      if (highByte) begin
         state_next = (addr == `FSCS_ID_ADDR_MAKER) ? TRIM_CODE : 8'hFF;
      end else begin
         case (addr)
            `FSCS_ID_ADDR_MAKER: state_next = MAKER_CODE;
            `FSCS_ID_ADDR_SIZE:  state_next = SIZE_CODE;
            `FSCS_ID_ADDR_PART:  state_next = PART_CODE;
            default:             state_next = 8'hFF;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) state_reg <= 8'h00;
      else     state_reg <= state_next;
   end

   assign dataOut = state_reg;
endmodule : fscs_ident_rom

`default_nettype wire

/* File: design/fscs_pkg.sv */
// Types of the fuse and identification store.
// Assumes fscs_cfg.svh sits on the include path.
`include "fscs_cfg.svh"

package fscs_pkg;

   // Fuse bytes as read: 0 means programmed
   typedef struct packed {
      logic [7:0] ext;
      logic [7:0] high;
      logic [7:0] low;
   } fscs_fuses_t;

   // Decoded configuration outputs, active high
   typedef struct packed {
      logic [2:0] brownoutLevel;
      logic       factoryTest;
      logic       debugEn;
      logic       scanPortEn;
      logic       serialProgEn;
      logic       watchdogForcedOn;
      logic       eepromKeepOnErase;
      logic [1:0] bootSize;
      logic       resetVectorBoot;
      logic       clockDivideByEight;
      logic       clockPinOutput;
      logic [1:0] startupTime;
      logic [3:0] clockSource;
   } fscs_config_t;

   // Programmer request to the store
   typedef struct packed {
      logic       fuseWrite;
      logic       fuseRead;
      logic       identRead;
      logic       lockWrite;
      logic       chipErase;
      logic [1:0] sel;
      logic       identHigh;
      logic [7:0] data;
   } fscs_req_t;

   typedef enum logic [1:0] {
      FSCS_IDLE      = 2'b00,
      FSCS_ERASE_MEM = 2'b01,
      FSCS_ERASE_LCK = 2'b10
   } fscs_erase_t;

endpackage : fscs_pkg

/* File: design/fscs_store.sv */
// Fuse store top: non-volatile fuse and lock bytes, latch shadows, ident reads, erase sequencing.
// Assumes programmer requests arrive as one-cycle pulses synchronous to clk;
// powerUp pulses once after reset release, memory erase done is reported by the memory block.
`timescale 1ns/1ps
`include "fscs_cfg.svh"
`default_nettype none

module fscs_store (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Mode
   input  wire logic                 powerUp,
   input  wire logic                 progMode,
   input  wire logic                 serialMode,
   // Programmer requests
   input  wire fscs_pkg::fscs_req_t  req,
   output logic                      readValid,
   output logic               [7:0]  readData,
   output logic                      busy,
   // Program memory erase handshake
   output logic                      memEraseStart,
   input  wire logic                 memEraseDone,
   // Configuration outputs
   output fscs_pkg::fscs_config_t    cfg,
   output logic               [7:0]  rcTrimRegister,
   output logic               [7:0]  lockByte
);
   typedef struct packed {
      fscs_pkg::fscs_fuses_t nv;
      fscs_pkg::fscs_fuses_t shadow;
      logic                  eeKeep;
      logic [7:0]            lockBits;
      logic                  progModeD;
      fscs_pkg::fscs_erase_t erase;
      logic                  eraseStart;
      logic                  readPend;
      logic                  identPend;
      logic [7:0]            readData;
      logic                  readValid;
      logic [7:0]            trim;
      logic                  trimLoad;
   } fscs_state_t;

   fscs_state_t state_reg;
   fscs_state_t state_next;
   logic [7:0]  identData;
   logic        lockFuses;
   logic [7:0]  highMask;

   fscs_ident_rom u_ident (
      .clk      (clk),
      .rst      (rst),
      .addr     (state_next.trimLoad ? `FSCS_ID_ADDR_MAKER : req.data[1:0]),
      .highByte (state_next.trimLoad | req.identHigh),
      .dataOut  (identData)
   );

   fscs_fuse_decode u_decode (
      .fuses      (state_reg.shadow),
      .eeKeepLive (state_reg.eeKeep),
      .cfg        (cfg)
   );

   assign lockFuses = ~state_reg.lockBits[`FSCS_BIT_LOCK1];
   assign highMask  = serialMode ? ~(8'h01 << `FSCS_BIT_SERIAL) : 8'hFF;

   always_comb begin
      state_next           = state_reg;
      state_next.readValid = 1'b0;
      state_next.readPend  = 1'b0;
      state_next.identPend = 1'b0;
      state_next.eraseStart = 1'b0;
      state_next.trimLoad  = 1'b0;
      state_next.progModeD = progMode;

      // Fuse write, refused when locked or busy erasing
      if (req.fuseWrite && progMode && !lockFuses && state_reg.erase == fscs_pkg::FSCS_IDLE) begin
         case (req.sel)
            `FSCS_SEL_LOW:  state_next.nv.low  = req.data;
            `FSCS_SEL_HIGH: state_next.nv.high = (req.data & highMask)
                                                 | (state_reg.nv.high & ~highMask);
            `FSCS_SEL_EXT:  state_next.nv.ext  = req.data | `FSCS_EXT_UNUSED;
            default:        state_next.nv.ext  = state_reg.nv.ext;
         endcase
      end

      // Lock bits can only move toward programmed outside erase
      if (req.lockWrite && progMode && state_reg.erase == fscs_pkg::FSCS_IDLE) begin
         state_next.lockBits = state_reg.lockBits & req.data;
      end

      // Immediate effect of the keep-EEPROM fuse
      state_next.eeKeep = state_next.nv.high[`FSCS_BIT_EEKEEP];

      // Deferred latch: entry to programming mode and power-up outside programming mode
      if ((progMode && !state_reg.progModeD) || (powerUp && !progMode)) begin
         state_next.shadow = state_reg.nv;
      end
      if (powerUp) begin
         state_next.trimLoad = 1'b1;
      end
      if (state_reg.trimLoad) begin
         state_next.trim = identData;
      end

      // Chip erase keeps fuses, clears locks after memory erase
      case (state_reg.erase)
         fscs_pkg::FSCS_IDLE: begin
            if (req.chipErase && progMode) begin
               state_next.erase      = fscs_pkg::FSCS_ERASE_MEM;
               state_next.eraseStart = 1'b1;
            end
         end
         fscs_pkg::FSCS_ERASE_MEM: begin
            if (memEraseDone) state_next.erase = fscs_pkg::FSCS_ERASE_LCK;
         end
         fscs_pkg::FSCS_ERASE_LCK: begin
            state_next.lockBits = `FSCS_LOCK_RESET;
            state_next.erase    = fscs_pkg::FSCS_IDLE;
         end
         default: state_next.erase = fscs_pkg::FSCS_IDLE;
      endcase

      // Reads: fuse/lock from current array, ident refused in the power-up trim load cycle
      if (req.fuseRead && progMode) begin
         state_next.readPend = 1'b1;
         case (req.sel)
            `FSCS_SEL_LOW:  state_next.readData = state_reg.nv.low;
            `FSCS_SEL_HIGH: state_next.readData = state_reg.nv.high;
            `FSCS_SEL_EXT:  state_next.readData = state_reg.nv.ext | `FSCS_EXT_UNUSED;
            default:        state_next.readData = state_reg.lockBits;
         endcase
      end else if (req.identRead && progMode && !state_next.trimLoad) begin
         state_next.identPend = 1'b1;
      end
      if (state_reg.readPend) begin
         state_next.readValid = 1'b1;
      end
      if (state_reg.identPend) begin
         state_next.readData  = identData;
         state_next.readValid = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg.nv.ext     <= `FSCS_EXT_RESET;
         state_reg.nv.high    <= `FSCS_HIGH_RESET;
         state_reg.nv.low     <= `FSCS_LOW_RESET;
         state_reg.shadow.ext <= `FSCS_EXT_RESET;
         state_reg.shadow.high <= `FSCS_HIGH_RESET;
         state_reg.shadow.low <= `FSCS_LOW_RESET;
         state_reg.eeKeep     <= 1'b1;
         state_reg.lockBits   <= `FSCS_LOCK_RESET;
         state_reg.progModeD  <= 1'b0;
         state_reg.erase      <= fscs_pkg::FSCS_IDLE;
         state_reg.eraseStart <= 1'b0;
         state_reg.readPend   <= 1'b0;
         state_reg.identPend  <= 1'b0;
         state_reg.readData   <= 8'h00;
         state_reg.readValid  <= 1'b0;
         state_reg.trim       <= 8'h00;
         state_reg.trimLoad   <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign readValid      = state_reg.readValid;
   assign readData       = state_reg.readData;
   assign busy           = state_reg.erase != fscs_pkg::FSCS_IDLE;
   assign memEraseStart  = state_reg.eraseStart;
   assign rcTrimRegister = state_reg.trim;
   assign lockByte       = state_reg.lockBits;
endmodule : fscs_store

`default_nettype wire

/* File: tb/fscs_mem_model.sv */
// Memory array stand-in that answers the store's erase start after a delay.
// Assumes memEraseStart is a one-cycle pulse on clk.
`timescale 1ns/1ps
`default_nettype none

module fscs_mem_model #(
   parameter int DLY = 4
) (
   // Clock
   input  wire logic clk,
   // Erase handshake
   input  wire logic start,
   output logic      done
);
   int cnt = 0;

   always @(posedge clk) begin
      done <= 1'b0;
      if (start)
         cnt <= DLY;
      else if (cnt == 1) begin
         cnt  <= 0;
         done <= 1'b1;
      end else if (cnt > 1)
         cnt <= cnt - 1;
   end
endmodule : fscs_mem_model

`default_nettype wire

/* File: tb/fscs_store_sva.sv */
// Checker on the fuse store ports: read latency, erase order, trim load, latch timing.
// Assumes the identification rom keeps its default trim code.
`timescale 1ns/1ps
`include "fscs_cfg.svh"
`default_nettype none

module fscs_store_sva #(
   parameter logic [7:0] TRIM_CODE = 8'h80  // Arbitrary value
) (
   // Clock and reset
   input wire logic                   clk,
   input wire logic                   rst,
   // Mode
   input wire logic                   powerUp,
   input wire logic                   progMode,
   // Programmer side
   input wire fscs_pkg::fscs_req_t    req,
   input wire logic                   readValid,
   input wire logic [7:0]             readData,
   input wire logic                   busy,
   // Erase handshake
   input wire logic                   memEraseStart,
   input wire logic                   memEraseDone,
   // Configuration
   input wire fscs_pkg::fscs_config_t cfg,
   input wire logic [7:0]             rcTrimRegister,
   input wire logic [7:0]             lockByte
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   logic                   progPrev;
   logic [3:0]             recentLatch;
   fscs_pkg::fscs_config_t cfgCore;

   // Latch event history, cleared with the store so no unknown leaks into the check
   always_ff @(posedge clk) begin
      if (rst) begin
         progPrev    <= 1'b0;
         recentLatch <= 4'h0;
      end else begin
         progPrev    <= progMode;
         recentLatch <= {recentLatch[2:0], powerUp || (progMode && !progPrev)};
      end
   end

   always_comb begin
      cfgCore = cfg;
      cfgCore.eepromKeepOnErase = 1'b0;
   end

   sequence s_erase_req;
      req.chipErase && progMode && !busy;
   endsequence
   sequence s_erase_end;
      ##2 (lockByte == `FSCS_LOCK_RESET && !busy);
   endsequence

   property p_erase_start;
      s_erase_req |=> busy && memEraseStart;
   endproperty
   property p_lock_hold;
      busy && !memEraseDone && !$past(memEraseDone) |=> $stable(lockByte);
   endproperty
   property p_erase_done;
      busy && memEraseDone |-> s_erase_end;
   endproperty
   property p_fuse_rd;
      req.fuseRead && progMode |-> ##2 readValid;
   endproperty
   property p_id_rd;
      req.identRead && progMode && !powerUp |-> ##2 readValid;
   endproperty
   property p_valid_src;
      readValid |-> $past(progMode && (req.fuseRead || req.identRead), 2);
   endproperty
   property p_ext_hi;
      readValid && $past(req.fuseRead && req.sel == `FSCS_SEL_EXT, 2) |-> readData[7:4] == 4'hF;
   endproperty
   property p_trim;
      powerUp |-> ##2 rcTrimRegister == TRIM_CODE;
   endproperty
   property p_cfg_hold;
      !$stable(cfgCore) |-> |recentLatch;
   endproperty

   a_erase_start: assert property (p_erase_start) else $error("erase start missing");
   a_lock_hold: assert property (p_lock_hold) else $error("lock bits moved early");
   a_erase_done: assert property (p_erase_done) else $error("lock clear late");
   a_fuse_rd: assert property (p_fuse_rd) else $error("fuse read latency");
   a_id_rd: assert property (p_id_rd) else $error("ident read latency");
   a_valid_src: assert property (p_valid_src) else $error("stray read valid");
   a_ext_hi: assert property (p_ext_hi) else $error("ext upper bits not 1");
   a_trim: assert property (p_trim) else $error("trim not loaded");
   a_cfg_hold: assert property (p_cfg_hold) else $error("config moved off latch");
endmodule : fscs_store_sva

bind fscs_store fscs_store_sva chk_u (.clk, .rst, .powerUp, .progMode, .req, .readValid, .readData,
   .busy, .memEraseStart, .memEraseDone, .cfg, .rcTrimRegister, .lockByte);

`default_nettype wire

/* File: tb/fscs_store_tb_top.sv */
// Self-checking bench of the fuse store: defaults, ident space, latching, lock and erase.
// Assumes the store and its erase partner model share one clock.
`timescale 1ns/1ps
`include "fscs_cfg.svh"
`default_nettype none

module fscs_store_tb_top;
   logic                   clk, rst, powerUp, progMode, serialMode;
   logic                   readValid, busy, memEraseStart, memEraseDone;
   logic [7:0]             readData, rcTrimRegister, lockByte;
   fscs_pkg::fscs_req_t    req;
   fscs_pkg::fscs_config_t cfg;
   int                     err_total = 0;
   int                     comparisons = 0;

   fscs_store dut_u (.clk, .rst, .powerUp, .progMode, .serialMode, .req, .readValid, .readData,
      .busy, .memEraseStart, .memEraseDone, .cfg, .rcTrimRegister, .lockByte);
   fscs_mem_model #(.DLY(4)) mem_u (.clk, .start(memEraseStart), .done(memEraseDone));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic results();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   function automatic fscs_pkg::fscs_config_t dec(input logic [7:0] e, h, l);
      dec = {e[3:1], ~e[0], ~h[7:3], h[2:1], ~h[0], ~l[7:6], l[5:0]};
   endfunction : dec

   // Waits for busy (b=1) or readValid (b=0) to reach lvl
   task automatic await(input logic b, input logic lvl);
      int n;
      for (n = 0; n < 30; n++) begin
         @(posedge clk);
         #1;
         if ((b ? busy : readValid) === lvl)
            break;
      end
      if (n == 30) begin
         err_total++;
         $display("[ERR] t=%0t wait got %h exp %h", $time, (b ? busy : readValid), lvl);
         results();
      end
   endtask : await

   task automatic send(input fscs_pkg::fscs_req_t r);
      @(posedge clk) req <= r;
      @(posedge clk) req <= '0;
   endtask : send

   task automatic wr(input logic [1:0] s, input logic [7:0] d);
      fscs_pkg::fscs_req_t r;
      r = '0;
      r.fuseWrite = (s != `FSCS_SEL_LOCK);
      r.lockWrite = (s == `FSCS_SEL_LOCK);
      r.sel = s;
      r.data = d;
      send(r);
   endtask : wr

   task automatic rd(input logic id, input logic [1:0] a, input logic hi, input logic [7:0] exp);
      fscs_pkg::fscs_req_t r;
      r = '0;
      r.fuseRead = !id;
      r.identRead = id;
      r.sel = a;
      r.identHigh = hi;
      r.data = {6'h00, a};
      send(r);
      await(1'b0, 1'b1);
      chk(readData, exp);
   endtask : rd

   task automatic setMode(input logic p, input logic s);
      @(posedge clk) progMode <= p;
      serialMode <= s;
      repeat (4) @(posedge clk);
   endtask : setMode

   task automatic t_defaults();
      @(posedge clk) powerUp <= 1'b1;
      @(posedge clk) powerUp <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(rcTrimRegister, 8'h80);
      chk(cfg, dec(`FSCS_EXT_RESET, `FSCS_HIGH_RESET, `FSCS_LOW_RESET));
      setMode(1'b1, 1'b0);
      rd(1'b0, `FSCS_SEL_EXT, 1'b0, 8'hFF);
      rd(1'b0, `FSCS_SEL_HIGH, 1'b0, 8'h99);
      rd(1'b0, `FSCS_SEL_LOW, 1'b0, 8'h62);
      chk(lockByte, 8'hFF);
      $display("t_defaults done");
   endtask : t_defaults

   task automatic t_ident();
      rd(1'b1, `FSCS_ID_ADDR_MAKER, 1'b0, 8'hA5);
      rd(1'b1, `FSCS_ID_ADDR_SIZE, 1'b0, 8'h5A);
      rd(1'b1, `FSCS_ID_ADDR_PART, 1'b0, 8'h3C);
      rd(1'b1, `FSCS_ID_ADDR_MAKER, 1'b1, 8'h80);
      $display("t_ident done");
   endtask : t_ident

   task automatic t_latch();
      wr(`FSCS_SEL_HIGH, 8'h91);
      wr(`FSCS_SEL_LOW, 8'hE2);
      wr(`FSCS_SEL_EXT, 8'h00);
      rd(1'b0, `FSCS_SEL_HIGH, 1'b0, 8'h91);
      rd(1'b0, `FSCS_SEL_EXT, 1'b0, 8'hF0);
      chk(cfg, dec(8'hFF, 8'h91, 8'h62));
      setMode(1'b0, 1'b0);
      setMode(1'b1, 1'b0);
      chk(cfg, dec(8'hF0, 8'h91, 8'hE2));
      $display("t_latch done");
   endtask : t_latch

   task automatic t_serial();
      setMode(1'b1, 1'b1);
      wr(`FSCS_SEL_HIGH, 8'hB9);
      rd(1'b0, `FSCS_SEL_HIGH, 1'b0, 8'h99);
      setMode(1'b1, 1'b0);
      $display("t_serial done");
   endtask : t_serial

   task automatic t_lock_erase();
      fscs_pkg::fscs_req_t r;
      wr(`FSCS_SEL_LOCK, 8'hFE);
      rd(1'b0, `FSCS_SEL_LOCK, 1'b0, 8'hFE);
      wr(`FSCS_SEL_HIGH, 8'h00);
      rd(1'b0, `FSCS_SEL_HIGH, 1'b0, 8'h99);
      chk(lockByte, 8'hFE);
      rd(1'b1, `FSCS_ID_ADDR_SIZE, 1'b0, 8'h5A);
      r = '0;
      r.chipErase = 1'b1;
      send(r);
      await(1'b1, 1'b1);
      chk(lockByte, 8'hFE);
      await(1'b1, 1'b0);
      chk(lockByte, 8'hFF);
      rd(1'b0, `FSCS_SEL_LOW, 1'b0, 8'hE2);
      rd(1'b0, `FSCS_SEL_EXT, 1'b0, 8'hF0);
      $display("t_lock_erase done");
   endtask : t_lock_erase

   // Normal-mode power-up must pick up bytes written since the last latch
   task automatic t_powerup();
      wr(`FSCS_SEL_LOW, 8'h62);
      setMode(1'b0, 1'b0);
      #1 chk(cfg, dec(8'hF0, 8'h99, 8'hE2));
      @(posedge clk) powerUp <= 1'b1;
      @(posedge clk) powerUp <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(cfg, dec(8'hF0, 8'h99, 8'h62));
      chk(rcTrimRegister, 8'h80);
      $display("t_powerup done");
   endtask : t_powerup

   initial begin
      rst = 1'b1;
      powerUp = 1'b0;
      progMode = 1'b0;
      serialMode = 1'b0;
      req = '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_defaults();
      t_ident();
      t_latch();
      t_serial();
      t_lock_erase();
      t_powerup();
      results();
   end
endmodule : fscs_store_tb_top

`default_nettype wire
